//--- qhp_host_model.sv
// Host processor bus model that runs whole bus cycles
`timescale 1ns/1ns
module qhp_host_model
    import qhp_pkg::*;
(
    input wire logic clk,
    input wire logic data_ack_n,
    input wire logic [DW-1:0] bus_in,
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic intr_ack_n,
    output logic [AW-1:0] reg_select_lines,
    output logic [DW-1:0] host_data
);
    // Idle bus at time zero
    initial begin
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        intr_ack_n = 1'b1;
        reg_select_lines = 6'h00;
        host_data = 8'h00;
    end
    // One bus cycle, held until acknowledge is sampled low or 40 cycles pass
    task automatic cycle(input qhp_kind_e kind, input logic [AW-1:0] a,
        input logic [DW-1:0] wd, output logic [DW-1:0] rd, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        chip_select_n <= (kind == K_IA);
        read_strobe_n <= (kind != K_RD);
        write_strobe_n <= (kind != K_WR);
        intr_ack_n <= (kind != K_IA);
        reg_select_lines <= a;
        host_data <= (kind == K_WR) ? wd : ~host_data;
        // Wait for acknowledge, bounded
        do begin
            @(posedge clk);
            n++;
        end while (data_ack_n !== 1'b0 && n < 40);
        ok = (data_ack_n === 1'b0);
        rd = bus_in;
        chip_select_n <= 1'b1;
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        intr_ack_n <= 1'b1;
        // Released bus no longer shows the old value
        host_data <= ~host_data;
        repeat (12) @(posedge clk);
    endtask
endmodule

//--- qhp_host_port.sv
// Host bus port, pin multiplexing and change-of-state logic of a quad UART
`timescale 1ns/1ns
module qhp_host_port
    import qhp_pkg::*;
#(
    parameter int BAUD_DIV = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic intr_ack_n,
    input wire logic [AW-1:0] reg_select_lines,
    input wire logic [DW-1:0] host_data_bus_in,
    output logic [DW-1:0] host_data_bus_out,
    output logic host_data_bus_oe_n,
    output logic data_ack_n_out,
    output logic data_ack_n_oe_n,
    output logic intr_request_n_out,
    output logic intr_request_n_oe_n,
    output logic [NCH-1:0] serial_tx_out,
    input wire logic [NCH-1:0] serial_rx_in,
    input wire logic [NCH-1:0] multi_pin_zero_in,
    output logic [NCH-1:0] multi_pin_zero_out,
    output logic [NCH-1:0] multi_pin_zero_oe_n,
    input wire logic [NCH-1:0] multi_pin_one_in,
    output logic [NCH-1:0] multi_pin_one_out,
    output logic [NCH-1:0] multi_pin_one_oe_n
);

    // Three-stage sampler and agreed value
    qhp_sync_s s1_reg, s2_reg, s3_reg, f_reg, fp_reg;
    qhp_sync_s raw, f_next;
    // Bus cycle control
    qhp_state_e state_reg, state_next;
    qhp_kind_e kind_reg;
    logic [DW-1:0] dout_reg;
    logic drive_reg;
    // Software visible state
    logic [7:0] cos_reg;
    logic [7:0] imr_reg;
    logic [3:0] opr_reg;
    logic [7:0] thr_reg;
    logic [7:0] ivr_reg;
    logic [7:0] cir_reg;
    logic [7:0] iop_reg [NCH];
    logic irq_reg;
    // Clock generation
    logic [15:0] div_reg;
    logic clk16_reg;
    logic [4:0] x1_reg;
    // Counter/timers, one per channel pair
    logic [CTW-1:0] ct_reg [2];
    logic [1:0] ct_out_reg;
    // Pin drivers
    logic [NCH-1:0] p0_out_reg, p0_oe_n_reg, p1_out_reg, p1_oe_n_reg;

    // Gather every foreign input for sampling
    assign raw = '{cs_n: chip_select_n, rd_n: read_strobe_n, wr_n: write_strobe_n,
        iack_n: intr_ack_n, addr: reg_select_lines, data: host_data_bus_in,
        rx: serial_rx_in, p0: multi_pin_zero_in, p1: multi_pin_one_in};
    // A bit changes only once stages two and three agree
    assign f_next = (s2_reg & s3_reg) | (f_reg & (s2_reg ^ s3_reg));

    // Sampler chain and filtered copy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= SYNC_RST;
            s2_reg <= SYNC_RST;
            s3_reg <= SYNC_RST;
            f_reg <= SYNC_RST;
            fp_reg <= SYNC_RST;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            f_reg <= f_next;
            fp_reg <= f_reg;
        end
    end

    // Access decode from filtered strobes
    wire idle = (state_reg == ST_IDLE);
    wire rd_go = !f_reg.cs_n && !f_reg.rd_n;
    wire wr_go = !f_reg.cs_n && !f_reg.wr_n;
    wire ia_go = !f_reg.iack_n && f_reg.cs_n;
    // Read wins over write, both over acknowledge
    wire take_rd = idle && rd_go;
    wire take_wr = idle && wr_go && !rd_go;
    wire take_ia = idle && ia_go && !rd_go && !wr_go;
    // cycle held while its strobe stays low
    wire held = (kind_reg == K_RD) ? rd_go :
                (kind_reg == K_WR) ? wr_go : !f_reg.iack_n;
    wire [AW-1:0] a = f_reg.addr;
    wire [DW-1:0] wd = f_reg.data;

    // Interrupt level and source
    wire [7:0] pend = cos_reg & imr_reg;
    logic [3:0] level;
    logic [2:0] src;
    // Count pending sources, pick the lowest numbered
    always_comb begin
        level = 4'h0;
        src = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            level = level + {3'h0, pend[i]};
            if (pend[i]) begin
                src = 3'(i);
            end
        end
    end
    wire [7:0] vector = thr_reg[THR_MOD] ? {ivr_reg[7:3], src} : ivr_reg;

    wire [7:0] rdata =
        (a == A_IPCR_AB) ? {4'h0, cos_reg[3:0]} :
        (a == A_IPCR_CD) ? {4'h0, cos_reg[7:4]} :
        (a == A_ISR_AB) ? {4'h0, pend[3:0]} :
        (a == A_ISR_CD) ? {4'h0, pend[7:4]} :
        (a == A_CTL_AB) ? ct_reg[0] :
        (a == A_CTL_CD) ? ct_reg[1] :
        (a == A_OPR_AB) ? {6'h00, opr_reg[1:0]} :
        (a == A_OPR_CD) ? {6'h00, opr_reg[3:2]} :
        (a == A_IPR_AB) ? {2'h0, f_reg.rx[1:0], f_reg.p1[1:0], f_reg.p0[1:0]} :
        (a == A_IPR_CD) ? {2'h0, f_reg.rx[3:2], f_reg.p1[3:2], f_reg.p0[3:2]} :
        (a == A_CIR) ? cir_reg :
        (a == A_THR) ? thr_reg :
        (a == A_IVR) ? ivr_reg : BYTE_ZERO;

    // change of state on both pins, {d1,d0,...,a1,a0}
    logic [7:0] cos_set, cos_clr;
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_cos
            assign cos_set[2*g] = f_reg.p0[g] ^ fp_reg.p0[g];
            assign cos_set[2*g+1] = f_reg.p1[g] ^ fp_reg.p1[g];
        end
    endgenerate
    // Reading a change register clears its nibble
    assign cos_clr = {{4{take_rd && a == A_IPCR_CD}}, {4{take_rd && a == A_IPCR_AB}}};

    // Bus cycle sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take_rd || take_wr || take_ia) begin
                    state_next = ST_ACK;
                end
            end
            ST_ACK: begin
                if (!held) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Cycle state, bus data and drive enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            kind_reg <= K_RD;
            dout_reg <= BYTE_ZERO;
            drive_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (take_rd) begin
                kind_reg <= K_RD;
                dout_reg <= rdata;
                drive_reg <= 1'b1;
            end else if (take_wr) begin
                kind_reg <= K_WR;
            end else if (take_ia) begin
                kind_reg <= K_IA;
                dout_reg <= vector;
                drive_reg <= 1'b1;
            end else if (state_next == ST_IDLE) begin
                drive_reg <= 1'b0;
            end
        end
    end

    // Interrupt state; a change in the clear cycle survives
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cos_reg <= BYTE_ZERO;
            cir_reg <= BYTE_ZERO;
            irq_reg <= 1'b0;
        end else begin
            cos_reg <= (cos_reg & ~cos_clr) | cos_set;
            irq_reg <= (level > thr_reg[3:0]);
            if (take_ia) begin
                cir_reg <= {level, 1'b0, src};
            end
        end
    end

    // shared registers written from the bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            imr_reg <= BYTE_ZERO;
            opr_reg <= 4'h0;
            thr_reg <= BYTE_ZERO;
            ivr_reg <= IVR_RST;
        end else if (take_wr) begin
            if (a == A_ISR_AB) imr_reg[3:0] <= wd[3:0];
            if (a == A_ISR_CD) imr_reg[7:4] <= wd[3:0];
            if (a == A_OPR_AB) opr_reg[1:0] <= wd[1:0];
            if (a == A_OPR_CD) opr_reg[3:2] <= wd[1:0];
            if (a == A_THR) thr_reg <= wd;
            if (a == A_IVR) ivr_reg <= wd;
        end
    end

    // 16X and 1X transmit/receive clocks from the system clock
    wire tick = (div_reg == 16'(BAUD_DIV - 1));
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg <= 16'h0000;
            clk16_reg <= 1'b0;
            x1_reg <= 5'h00;
        end else begin
            div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
            if (tick) begin
                clk16_reg <= !clk16_reg;
                x1_reg <= x1_reg + 5'h01;
            end
        end
    end
    wire clk1 = x1_reg[4];

    // counter/timer per pair: input on a/c, output on b/d
    generate
        for (g = 0; g < 2; g++) begin : g_ct
            wire ext = (iop_reg[2*g][IOP_P1_LSB +: 2] == P1_CT);
            wire rise = f_reg.p1[2*g] && !fp_reg.p1[2*g];
            wire inc = ext ? rise : tick;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ct_reg[g] <= {CTW{1'b0}};
                    ct_out_reg[g] <= 1'b0;
                end else if (inc) begin
                    ct_reg[g] <= ct_reg[g] + {{(CTW-1){1'b0}}, 1'b1};
                    if (&ct_reg[g]) ct_out_reg[g] <= !ct_out_reg[g];
                end
            end
        end
    endgenerate

    // Per channel pin control and pin drivers
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            wire [1:0] m0 = iop_reg[g][IOP_P0_LSB +: 2];
            wire [1:0] m1 = iop_reg[g][IOP_P1_LSB +: 2];
            wire c0 = iop_reg[g][IOP_P0_X16] ? clk16_reg : clk1;
            wire c1 = iop_reg[g][IOP_P1_X16] ? clk16_reg : clk1;
            // only b and d drive the counter output
            wire ct_drv = (m1 == P1_CT) && (g % 2 == 1);
            // first pin driven as clock or output only
            wire d0 = (m0 == P0_TXC) || (m0 == P0_GPO);
            wire o0 = (m0 == P0_GPO) ? opr_reg[g] : c0;
            // second pin driven as receive clock, or as counter output on b and d
            wire d1 = (m1 == P1_RXC_OUT) || ct_drv;
            wire o1 = ct_drv ? ct_out_reg[g/2] : c1;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    iop_reg[g] <= BYTE_ZERO;
                    p0_out_reg[g] <= 1'b1;
                    p0_oe_n_reg[g] <= 1'b1;
                    p1_out_reg[g] <= 1'b1;
                    p1_oe_n_reg[g] <= 1'b1;
                end else begin
                    if (take_wr && a == A_IOPCR[g]) iop_reg[g] <= wd;
                    p0_out_reg[g] <= d0 ? o0 : 1'b1;
                    p0_oe_n_reg[g] <= !d0;
                    p1_out_reg[g] <= d1 ? o1 : 1'b1;
                    p1_oe_n_reg[g] <= !d1;
                end
            end
        end
    endgenerate

    // Bus and open-drain outputs
    assign host_data_bus_out = dout_reg;
    assign host_data_bus_oe_n = !drive_reg;
    // acknowledge once data stands or is stored
    assign data_ack_n_out = OD_LOW;
    assign data_ack_n_oe_n = (state_reg != ST_ACK);
    assign intr_request_n_out = OD_LOW;
    assign intr_request_n_oe_n = !irq_reg;
    // transmit lines idle at mark; datapath lives elsewhere
    assign serial_tx_out = {NCH{LINE_MARK}};
    assign multi_pin_zero_out = p0_out_reg;
    assign multi_pin_zero_oe_n = p0_oe_n_reg;
    assign multi_pin_one_out = p1_out_reg;
    assign multi_pin_one_oe_n = p1_oe_n_reg;

endmodule

//--- qhp_host_port_sva.sv
// Port assertions for the quad UART host bus port
`timescale 1ns/1ns
module qhp_host_port_sva
    import qhp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic intr_ack_n,
    input wire logic host_data_bus_oe_n,
    input wire logic data_ack_n_out,
    input wire logic data_ack_n_oe_n,
    input wire logic intr_request_n_out,
    input wire logic [NCH-1:0] serial_tx_out,
    input wire logic [NCH-1:0] multi_pin_zero_oe_n,
    input wire logic [NCH-1:0] multi_pin_one_oe_n
);
    // Any host request on the pins: access or vector fetch
    wire logic req = (!chip_select_n && !(read_strobe_n && write_strobe_n))
        || (chip_select_n && !intr_ack_n);
    // Read access on the pins
    wire logic rd_req = !chip_select_n && !read_strobe_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reset_levels: assert property ($rose(rst_n) |-> data_ack_n_oe_n
        && host_data_bus_oe_n && &multi_pin_zero_oe_n && &multi_pin_one_oe_n)
        else $error("outputs not released after reset");
    a_ack_has_cause: assert property ($fell(data_ack_n_oe_n) |-> req)
        else $error("acknowledge without a request");
    a_ack_in_time: assert property (req [*6] |-> !data_ack_n_oe_n)
        else $error("acknowledge late");
    a_read_drives: assert property ($fell(data_ack_n_oe_n) && rd_req |-> !host_data_bus_oe_n)
        else $error("read acknowledged without bus drive");
    a_write_quiet: assert property (!write_strobe_n && !chip_select_n
        && !data_ack_n_oe_n |-> host_data_bus_oe_n)
        else $error("bus driven during write");
    a_drive_with_ack: assert property (!host_data_bus_oe_n |-> !data_ack_n_oe_n)
        else $error("bus driven without acknowledge");
    a_ack_release: assert property (!data_ack_n_oe_n && !req |-> ##[0:7] data_ack_n_oe_n)
        else $error("acknowledge not released");
    a_open_drain: assert property (data_ack_n_out == OD_LOW && intr_request_n_out == OD_LOW)
        else $error("open-drain output drives high");
    a_tx_idle: assert property (serial_tx_out == {NCH{LINE_MARK}})
        else $error("transmit line not at mark");
endmodule
bind qhp_host_port qhp_host_port_sva u_sva (.clk(clk), .rst_n(rst_n),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .intr_ack_n(intr_ack_n),
    .host_data_bus_oe_n(host_data_bus_oe_n), .data_ack_n_out(data_ack_n_out),
    .data_ack_n_oe_n(data_ack_n_oe_n), .intr_request_n_out(intr_request_n_out),
    .serial_tx_out(serial_tx_out), .multi_pin_zero_oe_n(multi_pin_zero_oe_n),
    .multi_pin_one_oe_n(multi_pin_one_oe_n));

//--- qhp_pkg.sv
// Constants, types and address map of the quad UART host bus port
package qhp_pkg;
    // Bus widths, channel count and counter width
    localparam int DW = 8;
    localparam int AW = 6;
    localparam int NCH = 4;
    localparam int CTW = 8;
    // Read addresses
    localparam logic [5:0] A_IPCR_AB = 6'h04;
    localparam logic [5:0] A_ISR_AB = 6'h05;
    localparam logic [5:0] A_CTL_AB = 6'h07;
    localparam logic [5:0] A_OPR_AB = 6'h0C;
    localparam logic [5:0] A_IPR_AB = 6'h0D;
    localparam logic [5:0] A_IPCR_CD = 6'h14;
    localparam logic [5:0] A_ISR_CD = 6'h15;
    localparam logic [5:0] A_CTL_CD = 6'h17;
    localparam logic [5:0] A_OPR_CD = 6'h1C;
    localparam logic [5:0] A_IPR_CD = 6'h1D;
    localparam logic [5:0] A_CIR = 6'h3D;
    localparam logic [5:0] A_THR = 6'h3E;
    localparam logic [5:0] A_IVR = 6'h3F;
    // Pin control register write address per channel a..d
    localparam logic [5:0] A_IOPCR [NCH] = '{6'h0D, 6'h0E, 6'h1D, 6'h1E};
    // Pin control fields and vector mode bit of THR
    localparam int IOP_P0_LSB = 0;
    localparam int IOP_P0_X16 = 2;
    localparam int IOP_P1_LSB = 4;
    localparam int IOP_P1_X16 = 6;
    localparam int THR_MOD = 7;
    // First pin modes
    localparam logic [1:0] P0_GPI = 2'h0;
    localparam logic [1:0] P0_CTS = 2'h1;
    localparam logic [1:0] P0_TXC = 2'h2;
    localparam logic [1:0] P0_GPO = 2'h3;
    // Second pin modes
    localparam logic [1:0] P1_GPI = 2'h0;
    localparam logic [1:0] P1_TXC_IN = 2'h1;
    localparam logic [1:0] P1_RXC_OUT = 2'h2;
    localparam logic [1:0] P1_CT = 2'h3;
    // Reset values and fixed levels
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] IVR_RST = 8'h00;
    localparam logic [3:0] NIB_ONES = 4'hF;
    localparam logic OD_LOW = 1'b0;
    localparam logic LINE_MARK = 1'b1;
    // Bus cycle states and kinds
    typedef enum logic {ST_IDLE, ST_ACK} qhp_state_e;
    typedef enum logic [1:0] {K_RD, K_WR, K_IA} qhp_kind_e;
    // Everything sampled from outside the clock domain
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic iack_n;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
        logic [NCH-1:0] rx;
        logic [NCH-1:0] p0;
        logic [NCH-1:0] p1;
    } qhp_sync_s;
    // Idle levels of the sampled inputs
    localparam qhp_sync_s SYNC_RST = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, iack_n: 1'b1,
        addr: 6'h00, data: 8'h00, rx: 4'hF, p0: 4'hF, p1: 4'hF};
endpackage

//--- tb_qhp_host_port.sv
// Self-checking testbench for the quad UART host bus port
`timescale 1ns/1ns
module tb_qhp_host_port;
    import qhp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [NCH-1:0] rx_drv = 4'hE;
    logic [NCH-1:0] p0_drv = 4'hF;
    logic [NCH-1:0] p1_drv = 4'hF;
    logic cs_n, rd_n, wr_n, ia_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] hdata, dout;
    logic dout_oe_n, ack_o, ack_oe_n, irq_o, irq_oe_n;
    logic [NCH-1:0] tx, p0_o, p0_oe_n, p1_o, p1_oe_n;
    int mismatches = 0;
    int samples_checked = 0;
    // Wire levels: pull-ups on open-drain lines, test drive on released pins
    wire logic ack_w = ack_oe_n ? 1'b1 : ack_o;
    wire logic irq_w = irq_oe_n ? 1'b1 : irq_o;
    wire logic [DW-1:0] bus_w = dout_oe_n ? hdata : dout;
    wire logic [NCH-1:0] p0_w = (p0_oe_n & p0_drv) | (~p0_oe_n & p0_o);
    wire logic [NCH-1:0] p1_w = (p1_oe_n & p1_drv) | (~p1_oe_n & p1_o);
    // Clock of 8 ns
    always #4 clk = ~clk;
    qhp_host_port u_dut (.clk(clk), .rst_n(rst_n), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .intr_ack_n(ia_n),
        .reg_select_lines(addr), .host_data_bus_in(bus_w), .host_data_bus_out(dout),
        .host_data_bus_oe_n(dout_oe_n), .data_ack_n_out(ack_o), .data_ack_n_oe_n(ack_oe_n),
        .intr_request_n_out(irq_o), .intr_request_n_oe_n(irq_oe_n), .serial_tx_out(tx),
        .serial_rx_in(rx_drv), .multi_pin_zero_in(p0_w), .multi_pin_zero_out(p0_o),
        .multi_pin_zero_oe_n(p0_oe_n), .multi_pin_one_in(p1_w), .multi_pin_one_out(p1_o),
        .multi_pin_one_oe_n(p1_oe_n));
    qhp_host_model u_host (.clk(clk), .data_ack_n(ack_w), .bus_in(bus_w),
        .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .intr_ack_n(ia_n), .reg_select_lines(addr), .host_data(hdata));
    // Compare one byte and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Bus cycle that must be acknowledged
    task automatic acc(input qhp_kind_e k, input logic [AW-1:0] a, input logic [7:0] wd,
        output logic [7:0] rd);
        logic ok;
        u_host.cycle(k, a, wd, rd, ok);
        chk({7'h00, ok}, 8'h01, "acknowledge");
    endtask
    // Registers written and read back, unmapped places, input port
    task automatic t_reg_rw();
        logic [7:0] d;
        acc(K_WR, A_IVR, 8'h5A, d);
        acc(K_RD, A_IVR, 8'h00, d);
        chk(d, 8'h5A, "vector readback");
        acc(K_WR, 6'h0F, 8'hFF, d);
        acc(K_RD, 6'h02, 8'h00, d);
        chk(d, BYTE_ZERO, "unmapped read");
        acc(K_RD, A_IVR, 8'h00, d);
        chk(d, 8'h5A, "unmapped write ignored");
        acc(K_RD, A_IPR_AB, 8'h00, d);
        chk({2'b00, d[5:0]}, 8'h2F, "input port");
    endtask
    // Change of state raises the request; vector fetch in both forms
    task automatic t_cos_irq();
        logic [7:0] d;
        acc(K_WR, A_IVR, 8'hAF, d);
        acc(K_WR, A_THR, BYTE_ZERO, d);
        acc(K_RD, A_IPCR_AB, 8'h00, d);
        acc(K_WR, A_ISR_AB, 8'h0F, d);
        chk({7'h00, irq_w}, 8'h01, "request idle");
        p0_drv[0] <= 1'b0;
        repeat (10) @(posedge clk);
        chk({7'h00, irq_w}, 8'h00, "request raised");
        acc(K_IA, 6'h00, 8'h00, d);
        chk(d, 8'hAF, "plain vector");
        // One pending source, number zero: level 1, source 0
        acc(K_RD, A_CIR, 8'h00, d);
        chk(d, 8'h10, "current interrupt updated");
        acc(K_WR, A_THR, 8'h80, d);
        acc(K_IA, 6'h00, 8'h00, d);
        chk(d, 8'hA8, "modified vector");
        acc(K_RD, A_IPCR_AB, 8'h00, d);
        chk(d, 8'h01, "change bit");
        acc(K_RD, A_IPCR_AB, 8'h00, d);
        chk(d, BYTE_ZERO, "change cleared");
        chk({7'h00, irq_w}, 8'h01, "request dropped");
    endtask
    // Every pin mode on channels a and b, then output port drive
    task automatic t_pin_modes();
        logic [7:0] d;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            acc(K_WR, A_IOPCR[0], {2'b00, m, 2'b00, m}, d);
            acc(K_WR, A_IOPCR[1], {2'b00, m, 2'b00, m}, d);
            chk({6'h00, p0_oe_n[1:0]}, m[1] ? 8'h00 : 8'h03, "first pin drive");
            chk({6'h00, p1_oe_n[1:0]}, {6'h00, !m[1], m != P1_RXC_OUT}, "second pin");
        end
        acc(K_WR, A_OPR_AB, 8'h01, d);
        chk({6'h00, p0_o[1:0]}, 8'h01, "output port a");
        acc(K_WR, A_OPR_AB, 8'h02, d);
        chk({6'h00, p0_o[1:0]}, 8'h02, "output port b");
    endtask
    // Level changes of a driven pin of channel a over a span of cycles
    task automatic count_edges(input logic which, input int span, output int n);
        logic prev;
        logic cur;
        n = 0;
        prev = which ? p1_o[0] : p0_o[0];
        repeat (span) begin
            @(posedge clk);
            cur = which ? p1_o[0] : p0_o[0];
            if (cur !== prev) begin
                n++;
            end
            prev = cur;
        end
    endtask
    // Clock outputs of channel a at 16X and 1X, then edges counted on its second pin
    task automatic t_clk_ct();
        logic [7:0] d;
        logic [7:0] c0;
        int n;
        // Default divider: 16X half period 4 cycles, 1X half period 64 cycles
        acc(K_WR, A_IOPCR[0], 8'h66, d);
        count_edges(1'b0, 16, n);
        chk(8'(n), 8'h04, "first pin 16X clock");
        count_edges(1'b1, 16, n);
        chk(8'(n), 8'h04, "second pin 16X clock");
        acc(K_WR, A_IOPCR[0], 8'h22, d);
        count_edges(1'b0, 128, n);
        chk(8'(n), 8'h02, "first pin 1X clock");
        acc(K_WR, A_IOPCR[0], 8'h30, d);
        acc(K_RD, A_CTL_AB, 8'h00, c0);
        repeat (3) begin
            p1_drv[0] <= 1'b0;
            repeat (8) @(posedge clk);
            p1_drv[0] <= 1'b1;
            repeat (8) @(posedge clk);
        end
        acc(K_RD, A_CTL_AB, 8'h00, d);
        chk(d, c0 + 8'h03, "counter input edges");
    endtask
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({ack_oe_n, dout_oe_n, irq_oe_n, p0_oe_n, 1'b1}, 8'hFF, "reset drive");
        chk({4'h0, p1_oe_n}, 8'h0F, "reset second pins");
        repeat (4) @(posedge clk);
        t_reg_rw();
        t_cos_irq();
        t_pin_modes();
        t_clk_ct();
        finish_test();
    end
    // Watchdog against a hung bus
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
endmodule
